/* oid_pkg.sv */
// Shared constants and types for the operand and immediate decoder.
// Assumes one core clock domain; all users reference names through oid_pkg::.
package oid_pkg;

  // ********************************************
  // Field widths
  // ********************************************
  localparam int unsigned IMM16_W = 16; // Long immediate in first source field
  localparam int unsigned IMM5_W = 5; // Short immediate width
  localparam int unsigned LBR_W = 26; // Long branch offset width
  localparam int unsigned SBR_W = 16; // Short branch offset width
  localparam int unsigned REG_W = 5; // Register designator, 32 registers
  localparam int unsigned PM_W = 8; // Pixel mask width

  // ********************************************
  // Constants and reset values
  // ********************************************
  localparam logic [31:0] IP_STEP = 32'h0000_0004; // Next instruction offset
  localparam logic [31:0] WORD_RST = 32'h0000_0000; // Reset of 32-bit outputs
  localparam logic [7:0] WIDTH_8 = 8'h08; // Byte size in bits
  localparam logic [7:0] WIDTH_16 = 8'h10; // Short size in bits
  localparam logic [7:0] WIDTH_32 = 8'h20; // Long size in bits
  localparam logic [7:0] WIDTH_64 = 8'h40; // Double size in bits
  localparam logic [7:0] WIDTH_128 = 8'h80; // Quad size in bits

  // ********************************************
  // Enumerations
  // ********************************************
  // Class of the operation consuming the first source field
  typedef enum logic [2:0] {
    OID_OP_LOGICAL,
    OID_OP_ADDSUB,
    OID_OP_ADDRESS,
    OID_OP_SHORT_IMM,
    OID_OP_REG_ONLY
  } oid_op_class_t;

  // Two-letter precision suffix: {source double, result double}
  typedef enum logic [1:0] {
    OID_PREC_SS = 2'h0,
    OID_PREC_SD = 2'h1,
    OID_PREC_DS = 2'h2,
    OID_PREC_DD = 2'h3
  } oid_prec_t;

  // Integer-size suffix class
  typedef enum logic [1:0] {
    OID_ISZ_B = 2'h0,
    OID_ISZ_S = 2'h1,
    OID_ISZ_L = 2'h2,
    OID_ISZ_BAD = 2'h3
  } oid_int_size_t;

  // Wide-size suffix class
  typedef enum logic [1:0] {
    OID_WSZ_L = 2'h0,
    OID_WSZ_D = 2'h1,
    OID_WSZ_Q = 2'h2,
    OID_WSZ_BAD = 2'h3
  } oid_wide_size_t;

  // Which instruction field a register designator goes to
  typedef enum logic [1:0] {
    OID_ROLE_FIRST_SOURCE_FIELD = 2'h0,
    OID_ROLE_SECOND_SOURCE_FIELD = 2'h1,
    OID_ROLE_DEST = 2'h2
  } oid_role_t;

endpackage : oid_pkg

/* oid_decode.sv */
// Operand and immediate decoder: extends immediates, selects constant halves,
// forms relative branch targets and checks precision and size suffixes.
// Assumes all inputs come from fetch logic on i_clk_sys; outputs one cycle later.
//
// Functional notes
// RULE_01: Logical immediate zero-extends to 32 bits
// RULE_02: Add, subtract, addressing immediate sign-extends
// RULE_03: Short 5-bit immediate zero-extends to 32
// RULE_04: Register-only field never yields an immediate
// RULE_05: Address offset sign-extends before address use
// RULE_06: Wide constant delivered one selected half
// RULE_07: Long branch offset signed 26-bit words
// RULE_08: Short branch offset signed 16-bit words
// RULE_09: Target is shifted extended offset plus ip+4
// RULE_10: Sources share precision; result same or higher (code checks only second source, allows .ds unless restricted)
// RULE_11: Restricted class forbids double-to-single suffix
// RULE_12: Integer sizes byte, short, long: 8/16/32
// RULE_13: Wide sizes long, double, quad: 32/64/128
// RULE_14: Pixel mask eight bits, bit zero least
// RULE_15: Designator picks one of 32 int/float registers
// RULE_16: Software writes back reserved bits as read
// RULE_17: Software zeroes reserved bits in memory layouts
// RULE_18: Branch target addition wraps modulo 2^32
`timescale 1ns/100ps

module oid_decode
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_valid,
  input wire oid_pkg::oid_op_class_t i_op_class,
  input wire logic i_use_imm,
  input wire logic [15:0] i_imm16,
  input wire logic [4:0] i_imm5,
  input wire logic [31:0] i_first_source_field_reg_value,
  input wire logic [31:0] i_wide_constant,
  input wire logic i_wide_high_sel,
  input wire logic i_branch_long,
  input wire logic [25:0] i_lbroff,
  input wire logic [15:0] i_sbroff,
  input wire logic [31:0] i_ip,
  input wire oid_pkg::oid_prec_t i_prec,
  input wire logic i_prec_restricted,
  input wire logic i_second_source_field_double,
  input wire oid_pkg::oid_int_size_t i_int_size,
  input wire oid_pkg::oid_wide_size_t i_wide_size,
  input wire logic [7:0] i_pixel_mask,
  input wire oid_pkg::oid_role_t i_role,
  input wire logic [4:0] i_first_source_field_desig,
  input wire logic [4:0] i_second_source_field_desig,
  input wire logic [4:0] i_dest_desig,
  input wire logic i_reg_is_float,
  output logic o_valid,
  output logic [31:0] o_operand,
  output logic o_operand_is_imm,
  output logic o_operand_err,
  output logic [15:0] o_const_half,
  output logic [31:0] o_branch_target,
  output logic o_prec_legal,
  output logic o_src_double,
  output logic o_res_double,
  output logic [7:0] o_int_width,
  output logic o_int_size_legal,
  output logic [7:0] o_wide_width,
  output logic o_wide_size_legal,
  output logic [7:0] o_pixel_mask,
  output logic [4:0] o_reg_index,
  output logic o_reg_is_float
);

  // ********************************************
  // Combinational decode
  // ********************************************
  logic [31:0] next_operand; // Extended first source operand
  logic next_is_imm; // Operand came from an immediate
  logic next_err; // Immediate requested where none allowed
  logic [31:0] brx_offset; // Shifted, sign-extended branch offset
  logic next_prec_legal; // Suffix and sources agree
  logic [7:0] next_int_width; // Integer operand width in bits
  logic [7:0] next_wide_width; // Transfer width in bits
  logic [4:0] next_reg_index; // Designator of the chosen field

  // First source field extension by operation class
  always_comb
  begin
    next_operand = i_first_source_field_reg_value;
    next_is_imm = 1'b0;
    next_err = 1'b0;
    case (i_op_class)
      oid_pkg::OID_OP_LOGICAL:
      begin
        if (i_use_imm)
        begin
          next_operand = {16'h0000, i_imm16}; // see RULE_01
          next_is_imm = 1'b1;
        end
      end
      oid_pkg::OID_OP_ADDSUB, oid_pkg::OID_OP_ADDRESS:
      begin
        if (i_use_imm)
        begin
          // Signed for arithmetic and every effective address; see RULE_02 RULE_05
          next_operand = {{16{i_imm16[15]}}, i_imm16};
          next_is_imm = 1'b1;
        end
      end
      oid_pkg::OID_OP_SHORT_IMM:
      begin
        if (i_use_imm)
        begin
          next_operand = {27'h0, i_imm5}; // see RULE_03
          next_is_imm = 1'b1;
        end
      end
      oid_pkg::OID_OP_REG_ONLY:
      begin
        // Register value passes; an immediate request is flagged; see RULE_04
        next_err = i_use_imm;
      end
      default:
      begin
        next_err = i_use_imm;
      end
    endcase
  end

  // Offsets are word counts, so two zero bits are appended; see RULE_07 RULE_08
  always_comb
  begin
    if (i_branch_long)
    begin
      brx_offset = {{4{i_lbroff[25]}}, i_lbroff, 2'h0};
    end
    else
    begin
      brx_offset = {{14{i_sbroff[15]}}, i_sbroff, 2'h0};
    end
  end

  // Second source must match suffix source precision; restricted class drops .ds
  always_comb
  begin
    next_prec_legal = (i_second_source_field_double == i_prec[1]); // see RULE_10
    if (i_prec_restricted && (i_prec == oid_pkg::OID_PREC_DS))
    begin
      next_prec_legal = 1'b0; // see RULE_11
    end
  end

  // Integer-size suffix to width; see RULE_12
  always_comb
  begin
    case (i_int_size)
      oid_pkg::OID_ISZ_B: next_int_width = oid_pkg::WIDTH_8;
      oid_pkg::OID_ISZ_S: next_int_width = oid_pkg::WIDTH_16;
      oid_pkg::OID_ISZ_L: next_int_width = oid_pkg::WIDTH_32;
      default: next_int_width = 8'h00;
    endcase
  end

  // Wide-size suffix to width; see RULE_13
  always_comb
  begin
    case (i_wide_size)
      oid_pkg::OID_WSZ_L: next_wide_width = oid_pkg::WIDTH_32;
      oid_pkg::OID_WSZ_D: next_wide_width = oid_pkg::WIDTH_64;
      oid_pkg::OID_WSZ_Q: next_wide_width = oid_pkg::WIDTH_128;
      default: next_wide_width = 8'h00;
    endcase
  end

  // Designator placed by operand role; see RULE_15
  always_comb
  begin
    case (i_role)
      oid_pkg::OID_ROLE_FIRST_SOURCE_FIELD: next_reg_index = i_first_source_field_desig;
      oid_pkg::OID_ROLE_SECOND_SOURCE_FIELD: next_reg_index = i_second_source_field_desig;
      oid_pkg::OID_ROLE_DEST: next_reg_index = i_dest_desig;
      default: next_reg_index = 5'h00;
    endcase
  end

  // ********************************************
  // Output registers
  // ********************************************
  // Operand path; all but o_valid held while no instruction is valid
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_valid <= 1'b0;
      o_operand <= oid_pkg::WORD_RST;
      o_operand_is_imm <= 1'b0;
      o_operand_err <= 1'b0;
      o_const_half <= 16'h0000;
      o_reg_index <= 5'h00;
      o_reg_is_float <= 1'b0;
    end
    else
    begin
      o_valid <= i_valid;
      if (i_valid)
      begin
        o_operand <= next_operand;
        o_operand_is_imm <= next_is_imm;
        o_operand_err <= next_err;
        // Only one half travels per instruction; see RULE_06
        o_const_half <= i_wide_high_sel ? i_wide_constant[31:16] : i_wide_constant[15:0];
        o_reg_index <= next_reg_index;
        o_reg_is_float <= i_reg_is_float;
      end
    end
  end

  // Branch target; 32-bit sum drops the carry so targets wrap modulo 2^32
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_branch_target <= oid_pkg::WORD_RST;
    end
    else if (i_valid)
    begin
      o_branch_target <= i_ip + oid_pkg::IP_STEP + brx_offset; // see RULE_09 RULE_18
    end
  end

  // Suffix decode results
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_prec_legal <= 1'b0;
      o_src_double <= 1'b0;
      o_res_double <= 1'b0;
      o_int_width <= 8'h00;
      o_int_size_legal <= 1'b0;
      o_wide_width <= 8'h00;
      o_wide_size_legal <= 1'b0;
    end
    else if (i_valid)
    begin
      o_prec_legal <= next_prec_legal;
      o_src_double <= i_prec[1];
      o_res_double <= i_prec[0];
      o_int_width <= next_int_width;
      o_int_size_legal <= (i_int_size != oid_pkg::OID_ISZ_BAD);
      o_wide_width <= next_wide_width;
      o_wide_size_legal <= (i_wide_size != oid_pkg::OID_WSZ_BAD);
    end
  end

  // Pixel mask held as bits 7..0, bit 0 least significant
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pixel_mask <= 8'h00;
    end
    else if (i_valid)
    begin
      o_pixel_mask <= i_pixel_mask; // see RULE_14
    end
  end

  // ********************************************
  // Assertions
  // ********************************************
  property p_logical_zero;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_valid && i_use_imm && i_op_class == oid_pkg::OID_OP_LOGICAL)
      |=> (o_operand[31:16] == 16'h0000) && (o_operand[15:0] == $past(i_imm16));
  endproperty
  a_logical_zero: assert property (p_logical_zero) // see RULE_01
    else $error("logical immediate not zero-extended");

  property p_arith_sign;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_valid && i_use_imm && (i_op_class == oid_pkg::OID_OP_ADDSUB ||
      i_op_class == oid_pkg::OID_OP_ADDRESS))
      |=> o_operand == {{16{$past(i_imm16[15])}}, $past(i_imm16)};
  endproperty
  a_arith_sign: assert property (p_arith_sign) // see RULE_02
    else $error("arithmetic or address immediate not sign-extended");

  property p_short_imm;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_valid && i_use_imm && i_op_class == oid_pkg::OID_OP_SHORT_IMM)
      |=> o_operand_is_imm && (o_operand == {27'h0, $past(i_imm5)});
  endproperty
  a_short_imm: assert property (p_short_imm) // see RULE_03
    else $error("short immediate wrong");

  property p_reg_only;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_valid && i_op_class == oid_pkg::OID_OP_REG_ONLY)
      |=> !o_operand_is_imm && (o_operand == $past(i_first_source_field_reg_value))
          && (o_operand_err == $past(i_use_imm));
  endproperty
  a_reg_only: assert property (p_reg_only) // see RULE_04
    else $error("register-only field produced an immediate");

  property p_const_half;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_valid |=> o_const_half == ($past(i_wide_high_sel) ?
      $past(i_wide_constant[31:16]) : $past(i_wide_constant[15:0]));
  endproperty
  a_const_half: assert property (p_const_half) // see RULE_06
    else $error("wrong constant half selected");

  property p_branch;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_valid |=> (o_branch_target - $past(i_ip) - 32'h0000_0004) == ($past(i_branch_long) ?
      {{4{$past(i_lbroff[25])}}, $past(i_lbroff), 2'h0} :
      {{14{$past(i_sbroff[15])}}, $past(i_sbroff), 2'h0});
  endproperty
  a_branch: assert property (p_branch) // see RULE_09
    else $error("branch target wrong");

  property p_prec;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_valid && i_prec_restricted && i_prec == oid_pkg::OID_PREC_DS) |=> !o_prec_legal;
  endproperty
  a_prec: assert property (p_prec) // see RULE_11
    else $error("double-to-single accepted in restricted class");

  property p_prec_match;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_valid && i_second_source_field_double != i_prec[1]) |=> !o_prec_legal;
  endproperty
  a_prec_match: assert property (p_prec_match) // see RULE_10
    else $error("mixed source precision accepted");

  property p_int_size;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_valid && i_int_size == oid_pkg::OID_ISZ_S) |=> o_int_width == 8'h10 && o_int_size_legal;
  endproperty
  a_int_size: assert property (p_int_size) // see RULE_12
    else $error("short size not 16 bits");

  property p_wide_size;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_valid && i_wide_size == oid_pkg::OID_WSZ_Q) |=> o_wide_width == 8'h80;
  endproperty
  a_wide_size: assert property (p_wide_size) // see RULE_13
    else $error("quad size not 128 bits");

  property p_pmask;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_valid |=> o_pixel_mask[0] == $past(i_pixel_mask[0]) && o_pixel_mask == $past(i_pixel_mask);
  endproperty
  a_pmask: assert property (p_pmask) // see RULE_14
    else $error("pixel mask order wrong");

  c_long_branch: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_valid && i_branch_long && i_lbroff[25]);
  c_wrap: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_valid && i_ip[31] && !i_branch_long && !i_sbroff[15]);
  c_reg_only_err: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_valid && i_op_class == oid_pkg::OID_OP_REG_ONLY && i_use_imm);
  c_high_half: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_valid && i_wide_high_sel);

endmodule : oid_decode

/* oid_decode_tb.sv */
// Self-checking bench for the operand and immediate decoder.
// Assumes oid_pkg is compiled first and the decoder answers right after
// each taken edge, holding all outputs but o_valid until the next instruction.
`timescale 1ns/100ps

module oid_decode_tb;

  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic i_clk_sys, i_rst_b, i_valid, i_use_imm, i_wide_high_sel, i_branch_long;
  oid_pkg::oid_op_class_t i_op_class; // Operation class
  logic [15:0] i_imm16, i_sbroff;
  logic [4:0] i_imm5, i_first_source_field_desig, i_second_source_field_desig, i_dest_desig;
  logic [31:0] i_first_source_field_reg_value, i_wide_constant, i_ip;
  logic [25:0] i_lbroff; // Long branch offset
  oid_pkg::oid_prec_t i_prec; // Precision suffix
  logic i_prec_restricted, i_second_source_field_double, i_reg_is_float;
  oid_pkg::oid_int_size_t i_int_size;
  oid_pkg::oid_wide_size_t i_wide_size;
  logic [7:0] i_pixel_mask;
  oid_pkg::oid_role_t i_role; // Operand role
  logic o_valid, o_operand_is_imm, o_operand_err, o_prec_legal, o_src_double;
  logic o_res_double, o_int_size_legal, o_wide_size_legal, o_reg_is_float;
  logic [31:0] o_operand, o_branch_target;
  logic [15:0] o_const_half;
  logic [7:0] o_int_width, o_wide_width, o_pixel_mask;
  logic [4:0] o_reg_index;
  int fails; // Mismatch count
  int check_count; // Comparison count

  oid_decode dut
  (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_valid(i_valid),
    .i_op_class(i_op_class), .i_use_imm(i_use_imm), .i_imm16(i_imm16),
    .i_imm5(i_imm5), .i_first_source_field_reg_value(i_first_source_field_reg_value),
    .i_wide_constant(i_wide_constant), .i_wide_high_sel(i_wide_high_sel),
    .i_branch_long(i_branch_long), .i_lbroff(i_lbroff), .i_sbroff(i_sbroff),
    .i_ip(i_ip), .i_prec(i_prec), .i_prec_restricted(i_prec_restricted),
    .i_second_source_field_double(i_second_source_field_double), .i_int_size(i_int_size),
    .i_wide_size(i_wide_size), .i_pixel_mask(i_pixel_mask), .i_role(i_role),
    .i_first_source_field_desig(i_first_source_field_desig), .i_second_source_field_desig(i_second_source_field_desig),
    .i_dest_desig(i_dest_desig), .i_reg_is_float(i_reg_is_float),
    .o_valid(o_valid), .o_operand(o_operand), .o_operand_is_imm(o_operand_is_imm),
    .o_operand_err(o_operand_err), .o_const_half(o_const_half),
    .o_branch_target(o_branch_target), .o_prec_legal(o_prec_legal),
    .o_src_double(o_src_double), .o_res_double(o_res_double),
    .o_int_width(o_int_width), .o_int_size_legal(o_int_size_legal),
    .o_wide_width(o_wide_width), .o_wide_size_legal(o_wide_size_legal),
    .o_pixel_mask(o_pixel_mask), .o_reg_index(o_reg_index),
    .o_reg_is_float(o_reg_is_float)
  );

  // ****************************************
  // Clock, 8 ns period
  // ****************************************
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // ****************************************
  // Shared helpers
  // ****************************************
  // Compare one value; a 1-bit flag is widened, so an unknown still fails
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  // Fields are already set with valid high; this edge takes them
  task automatic take;
    @(posedge i_clk_sys);
    i_valid <= 1'b0;
    #1;
    chk("o_valid", 32'h1, {31'h0, o_valid});
  endtask : take

  // Issue one first-source operand
  task automatic send_op(input oid_pkg::oid_op_class_t c, input logic u,
                         input logic [15:0] imm, input logic [4:0] imm5);
    @(posedge i_clk_sys);
    i_op_class <= c;
    i_use_imm <= u;
    i_imm16 <= imm;
    i_imm5 <= imm5;
    i_valid <= 1'b1;
    take();
  endtask : send_op

  // One branch; the expected target is worked out by hand, wrapping at 32 bits
  task automatic br(input logic lng, input logic [25:0] l, input logic [15:0] s,
                    input logic [31:0] ip, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_branch_long <= lng;
    i_lbroff <= l;
    i_sbroff <= s;
    i_ip <= ip;
    i_valid <= 1'b1;
    take();
    chk("target", exp, o_branch_target);
  endtask : br

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // ****************************************
  // Scenarios
  // ****************************************
  // Immediate extension per operation class, register fallback
  task automatic t_imm;
    i_first_source_field_reg_value <= 32'hA5A5_5A5A;
    send_op(oid_pkg::OID_OP_LOGICAL, 1'b1, 16'h8000, 5'h00);
    chk("logical", 32'h0000_8000, o_operand);
    chk("logical_imm", 32'h1, {31'h0, o_operand_is_imm});
    send_op(oid_pkg::OID_OP_ADDSUB, 1'b1, 16'h8000, 5'h00);
    chk("addsub", 32'hFFFF_8000, o_operand);
    send_op(oid_pkg::OID_OP_ADDRESS, 1'b1, 16'h8001, 5'h00);
    chk("addr_neg", 32'hFFFF_8001, o_operand);
    send_op(oid_pkg::OID_OP_ADDRESS, 1'b1, 16'h7FFF, 5'h00);
    chk("addr_pos", 32'h0000_7FFF, o_operand);
    send_op(oid_pkg::OID_OP_SHORT_IMM, 1'b1, 16'hFFFF, 5'h1F);
    chk("short", 32'h0000_001F, o_operand);
    send_op(oid_pkg::OID_OP_REG_ONLY, 1'b1, 16'h1234, 5'h00);
    chk("regonly_err", 32'h1, {31'h0, o_operand_err});
    chk("regonly_imm", 32'h0, {31'h0, o_operand_is_imm});
    send_op(oid_pkg::OID_OP_ADDSUB, 1'b0, 16'h8000, 5'h00);
    chk("reg_value", 32'hA5A5_5A5A, o_operand);
    chk("reg_err", 32'h0, {31'h0, o_operand_err});
  endtask : t_imm

  // One half of the wide constant each instruction
  task automatic t_half;
    for (int h = 0; h < 2; h++)
    begin
      @(posedge i_clk_sys);
      i_wide_constant <= 32'h1234_ABCD;
      i_wide_high_sel <= h[0];
      i_valid <= 1'b1;
      take();
      chk("const_half", h ? 32'h1234 : 32'hABCD, {16'h0, o_const_half});
    end
  endtask : t_half

  // Long and short offsets, sign, boundaries and wrap
  task automatic t_branch;
    br(1'b0, 26'h0, 16'hFFFF, 32'h0000_0100, 32'h0000_0100);
    br(1'b0, 26'h0, 16'h8000, 32'h0001_0000, 32'hFFFF_0004);
    br(1'b1, 26'h1FF_FFFF, 16'h0, 32'h0000_0000, 32'h0800_0000);
    br(1'b1, 26'h200_0000, 16'h0, 32'h1000_0000, 32'h0800_0004);
    br(1'b1, 26'h000_0001, 16'h0, 32'hFFFF_FFF8, 32'h0000_0000);
  endtask : t_branch

  // Every precision suffix, restricted or not, matching or not
  task automatic t_prec;
    logic exp;
    for (int k = 0; k < 16; k++)
    begin
      @(posedge i_clk_sys);
      i_prec <= oid_pkg::oid_prec_t'(k[1:0]);
      i_prec_restricted <= k[2];
      i_second_source_field_double <= k[3];
      i_valid <= 1'b1;
      take();
      exp = (k[3] == k[1]) && !(k[2] && k[1:0] == 2'h2);
      chk("prec_legal", {31'h0, exp}, {31'h0, o_prec_legal});
      chk("src_res", {30'h0, k[1:0]}, {30'h0, o_src_double, o_res_double});
    end
  endtask : t_prec

  // Integer and wide size codes, including the unmapped one
  task automatic t_size;
    logic [7:0] iw [4];
    logic [7:0] ww [4];
    iw = '{8'h08, 8'h10, 8'h20, 8'h00};
    ww = '{8'h20, 8'h40, 8'h80, 8'h00};
    for (int k = 0; k < 4; k++)
    begin
      @(posedge i_clk_sys);
      i_int_size <= oid_pkg::oid_int_size_t'(k[1:0]);
      i_wide_size <= oid_pkg::oid_wide_size_t'(k[1:0]);
      i_valid <= 1'b1;
      take();
      chk("int_width", {24'h0, iw[k]}, {24'h0, o_int_width});
      chk("int_legal", {31'h0, k != 3}, {31'h0, o_int_size_legal});
      chk("wide_width", {24'h0, ww[k]}, {24'h0, o_wide_width});
      chk("wide_legal", {31'h0, k != 3}, {31'h0, o_wide_size_legal});
    end
  endtask : t_size

  // Roles pick distinct fields; mask bit order kept; back to back
  task automatic t_role_mask;
    logic [4:0] exp [3];
    exp = '{5'h03, 5'h1C, 5'h1F};
    @(posedge i_clk_sys);
    {i_first_source_field_desig, i_second_source_field_desig, i_dest_desig} <= {5'h03, 5'h1C, 5'h1F};
    i_role <= oid_pkg::OID_ROLE_FIRST_SOURCE_FIELD;
    i_pixel_mask <= 8'h01;
    i_reg_is_float <= 1'b1;
    i_valid <= 1'b1;
    for (int k = 1; k < 3; k++)
    begin
      @(posedge i_clk_sys);
      i_role <= oid_pkg::oid_role_t'(k[1:0]);
      i_pixel_mask <= 8'h80 >> (k - 1);
      i_reg_is_float <= k[1];
      #1;
      chk("reg_index", {27'h0, exp[k-1]}, {27'h0, o_reg_index});
      chk("pixel_mask", k == 1 ? 32'h01 : 32'h80, {24'h0, o_pixel_mask});
      chk("reg_float", {31'h0, k == 1}, {31'h0, o_reg_is_float});
    end
    take();
    chk("reg_dest", {27'h0, exp[2]}, {27'h0, o_reg_index});
    chk("mask_bit6", 32'h40, {24'h0, o_pixel_mask});
    @(posedge i_clk_sys);
    #1;
    chk("o_valid_drop", 32'h0, {31'h0, o_valid});
    chk("index_hold", {27'h0, exp[2]}, {27'h0, o_reg_index});
  endtask : t_role_mask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    fails = 0;
    check_count = 0;
    // Bench holds reset and valid low and keeps unused words zero
    {i_rst_b, i_valid, i_use_imm, i_wide_high_sel, i_branch_long} = '0;
    {i_imm16, i_sbroff, i_imm5, i_first_source_field_desig, i_second_source_field_desig, i_dest_desig} = '0;
    {i_first_source_field_reg_value, i_wide_constant, i_ip, i_lbroff} = '0;
    {i_prec_restricted, i_second_source_field_double, i_reg_is_float, i_pixel_mask} = '0;
    i_op_class = oid_pkg::OID_OP_LOGICAL;
    i_prec = oid_pkg::OID_PREC_SS;
    i_int_size = oid_pkg::OID_ISZ_B;
    i_wide_size = oid_pkg::OID_WSZ_L;
    i_role = oid_pkg::OID_ROLE_FIRST_SOURCE_FIELD;
    repeat (5) @(posedge i_clk_sys);
    #1;
    chk("rst_valid", 32'h0, {31'h0, o_valid});
    chk("rst_operand", 32'h0, o_operand);
    chk("rst_target", 32'h0, o_branch_target);
    @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_imm();
    t_half();
    t_branch();
    t_prec();
    t_size();
    t_role_mask();
    wrap_up();
  end

endmodule : oid_decode_tb
